// *** design/mslk_regs.svh ***
`ifndef MSLK_REGS_SVH
`define MSLK_REGS_SVH

// ----------------------------------------------------------------
// clock and bit timing
// ----------------------------------------------------------------
`define MSLK_CLK_HZ 125000000
`define MSLK_BAUD 9600
`define MSLK_BAUD_MIN 4800
`define MSLK_BAUD_MAX 28800
`define MSLK_BIT_CYC (`MSLK_CLK_HZ / `MSLK_BAUD)

// ----------------------------------------------------------------
// strap capture: edges after reset release before the synchronised
// pins show the levels that stood at the release
// ----------------------------------------------------------------
`define MSLK_STRAP_SETTLE 2'h2

// ----------------------------------------------------------------
// frame shapes, sent least significant bit first
// ----------------------------------------------------------------
`define MSLK_FRAME_BITS 4'hA
`define MSLK_BRK_BITS 4'hA
`define MSLK_BRK_ECHO_BITS 4'hC
`define MSLK_BRK_PAT 12'h000
`define MSLK_BRK_ECHO_PAT 12'h003

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define MSLK_OP_READ 8'h4A
`define MSLK_OP_WRITE 8'h49
`define MSLK_OP_INDEXED_READ_CMD 8'h1A
`define MSLK_OP_INDEXED_WRITE_CMD 8'h19
`define MSLK_OP_STACK_POINTER_READ_CMD 8'h0C
`define MSLK_OP_RUN 8'h28

// ----------------------------------------------------------------
// vector addresses (high byte location)
// ----------------------------------------------------------------
`define MSLK_VEC_RST_USER 16'hFFFE
`define MSLK_VEC_SWI_USER 16'hFFFC
`define MSLK_VEC_RST_MON 16'hFEFE
`define MSLK_VEC_SWI_MON 16'hFEFC

`endif

// *** design/mslk_pkg.sv ***
package mslk_pkg;

   // ----------------------------------------------------------------
   // command interpreter states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_BOOT_BREAK = 3'b000,
      ST_OPCODE = 3'b001,
      ST_ADDR_HI = 3'b010,
      ST_ADDR_LO = 3'b011,
      ST_DATA = 3'b100,
      ST_RESPOND = 3'b101,
      ST_READ_ISSUE = 3'b110,
      ST_READ_LOAD = 3'b111
   } mslk_state_e;

   typedef logic [7:0] mslk_byte_t;

endpackage : mslk_pkg

// *** design/mslk_tx.sv ***
`timescale 1ns/1ns
`include "mslk_regs.svh"

module mslk_tx #(
   parameter int unsigned BIT_CYC = `MSLK_BIT_CYC,
   parameter int unsigned PAT_W = 12
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // pattern request
   input wire logic start_i,
   input wire logic [PAT_W-1:0] pat_i,
   input wire logic [3:0] nbits_i,
   // line side
   output logic line_o,
   output logic busy_o
);

   localparam int unsigned CW = $clog2(BIT_CYC + 1);

   logic [CW-1:0] cnt_ff;
   logic [3:0] left_ff;
   logic [PAT_W-1:0] sh_ff;
   logic line_ff;
   logic busy_ff;

   wire logic tick = busy_ff & (cnt_ff == '0);
   wire logic last = left_ff == 4'h1;

   // ----------------------------------------------------------------
   // bit shifter: each bit stands one full bit time
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_ff <= '0;
         left_ff <= 4'h0;
         sh_ff <= '0;
         line_ff <= 1'b1;
         busy_ff <= 1'b0;
      end else if (start_i && !busy_ff) begin
         cnt_ff <= CW'(BIT_CYC - 1);
         left_ff <= nbits_i;
         sh_ff <= pat_i;
         line_ff <= pat_i[0];
         busy_ff <= 1'b1;
      end else if (tick) begin
         cnt_ff <= CW'(BIT_CYC - 1);
         left_ff <= left_ff - 4'h1;
         sh_ff <= sh_ff >> 1;
         // released line idles high through the pull-up
         line_ff <= last ? 1'b1 : sh_ff[1];
         busy_ff <= !last;
      end else if (busy_ff) begin
         cnt_ff <= cnt_ff - CW'(1);
      end
   end

   assign line_o = line_ff;
   assign busy_o = busy_ff;

endmodule : mslk_tx

// *** design/mslk_link.sv ***
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`include "mslk_regs.svh"

module mslk_link #(
   parameter int unsigned BIT_CYC = `MSLK_BIT_CYC
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic NRST_I,
   // mode straps and configuration
   input wire logic IRQ_TEST_HIGH_VOLTAGE_I,
   input wire logic RST_TEST_HIGH_VOLTAGE_I,
   input wire logic MODE_STRAP_A_I,
   input wire logic MODE_STRAP_B_I,
   input wire logic DIVIDER_BYPASS_STRAP_I,
   input wire logic WATCHDOG_DISABLE_BIT_I,
   // monitor serial pin, open drain
   input wire logic MONITOR_SERIAL_PIN_I,
   output logic MONITOR_SERIAL_PIN_O,
   output logic MONITOR_SERIAL_PIN_OE_O,
   // mode results
   output logic MONITOR_MODE_O,
   output logic BUS_CLK_DIV4_O,
   output logic WATCHDOG_ENABLE_O,
   output logic WATCHDOG_RUN_O,
   output logic [15:0] RESET_VECTOR_O,
   output logic [15:0] SWI_VECTOR_O,
   output logic RAM_JUMP_O,
   output logic RETURN_FROM_INTERRUPT_O,
   // memory and cpu port
   output logic [15:0] MEM_ADDR_O,
   output logic [7:0] MEM_WDATA_O,
   output logic MEM_WE_O,
   output logic MEM_RE_O,
   input wire logic [7:0] MEM_RDATA_I,
   input wire logic [15:0] STACK_POINTER_I
);

   localparam int unsigned CW = $clog2(BIT_CYC + 1);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [5:0] pin_meta_ff;
   logic [5:0] pin_sync_ff;
   wire logic [5:0] pins_raw = {IRQ_TEST_HIGH_VOLTAGE_I,
      RST_TEST_HIGH_VOLTAGE_I, MODE_STRAP_A_I, MODE_STRAP_B_I,
      DIVIDER_BYPASS_STRAP_I, MONITOR_SERIAL_PIN_I};

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         pin_meta_ff <= 6'h01;
         pin_sync_ff <= 6'h01;
      end else begin
         pin_meta_ff <= pins_raw;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   wire logic irq_test_high_voltage = pin_sync_ff[5];
   wire logic rst_test_high_voltage = pin_sync_ff[4];
   wire logic strap_a = pin_sync_ff[3];
   wire logic strap_b = pin_sync_ff[2];
   wire logic bypass_strap = pin_sync_ff[1];
   wire logic rx_line = pin_sync_ff[0];

   // ----------------------------------------------------------------
   // mode capture at reset release
   // ----------------------------------------------------------------
   logic [1:0] settle_ff;
   logic latched_ff;
   logic monitor_ff;
   logic div4_ff;
   logic ram_jump_ff;
   logic ram_mode_ff;

   wire logic strap_ok = irq_test_high_voltage & strap_a & ~strap_b;
   wire logic mon_sel = strap_ok & rx_line;
   wire logic ram_sel = strap_ok & ~rx_line;
   wire logic catch_now = !latched_ff && settle_ff == `MSLK_STRAP_SETTLE;

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         settle_ff <= 2'h0;
         latched_ff <= 1'b0;
         monitor_ff <= 1'b0;
         div4_ff <= 1'b1;
         ram_jump_ff <= 1'b0;
         ram_mode_ff <= 1'b0;
      end else if (catch_now) begin
         // mode held from here on whatever the pins do; ram_jump_ff pulses for one cycle only
         latched_ff <= 1'b1;
         monitor_ff <= mon_sel;
         div4_ff <= !mon_sel || bypass_strap;
         ram_jump_ff <= ram_sel;
         ram_mode_ff <= ram_sel;
      end else begin
         if (!latched_ff) begin
            settle_ff <= settle_ff + 2'h1;
         end
         ram_jump_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // vectors and watchdog
   // ----------------------------------------------------------------
   logic [15:0] rst_vec_ff;
   logic [15:0] swi_vec_ff;
   logic wd_en_ff;

   wire logic mon_like = monitor_ff | ram_mode_ff;

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rst_vec_ff <= `MSLK_VEC_RST_USER;
         swi_vec_ff <= `MSLK_VEC_SWI_USER;
         wd_en_ff <= 1'b0;
      end else if (latched_ff) begin
         // downloaded code still returns through the monitor vector
         rst_vec_ff <= mon_like ? `MSLK_VEC_RST_MON
                                : `MSLK_VEC_RST_USER;
         swi_vec_ff <= mon_like ? `MSLK_VEC_SWI_MON
                                : `MSLK_VEC_SWI_USER;
         wd_en_ff <= !(mon_like && (irq_test_high_voltage || rst_test_high_voltage));
      end
   end

   assign WATCHDOG_RUN_O = wd_en_ff & ~WATCHDOG_DISABLE_BIT_I;

   // ----------------------------------------------------------------
   // receiver: samples mid-bit, receiver is shut while we transmit
   // ----------------------------------------------------------------
   logic rx_act_ff;
   logic [CW-1:0] rx_cnt_ff;
   logic [3:0] rx_idx_ff;
   mslk_pkg::mslk_byte_t rx_sh_ff;
   logic rx_done_ff;
   logic rx_brk_ff;
   logic tx_busy;
   mslk_pkg::mslk_state_e state_ff;
   mslk_pkg::mslk_state_e nxt_state;

   wire logic listening = state_ff == mslk_pkg::ST_OPCODE
      || state_ff == mslk_pkg::ST_ADDR_HI
      || state_ff == mslk_pkg::ST_ADDR_LO
      || state_ff == mslk_pkg::ST_DATA;
   wire logic rx_start = !rx_act_ff && !rx_done_ff && !tx_busy
      && listening && !rx_line;
   wire logic rx_tick = rx_act_ff && rx_cnt_ff == '0;
   wire logic rx_stop = rx_idx_ff == 4'h9;
   wire logic rx_zero = rx_sh_ff == 8'h00;

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rx_act_ff <= 1'b0;
         rx_cnt_ff <= '0;
         rx_idx_ff <= 4'h0;
         rx_sh_ff <= 8'h00;
         rx_done_ff <= 1'b0;
         rx_brk_ff <= 1'b0;
      end else begin
         rx_done_ff <= 1'b0;
         if (rx_start) begin
            rx_act_ff <= 1'b1;
            rx_cnt_ff <= CW'(BIT_CYC / 2);
            rx_idx_ff <= 4'h0;
         end else if (rx_tick) begin
            rx_cnt_ff <= CW'(BIT_CYC - 1);
            rx_idx_ff <= rx_idx_ff + 4'h1;
            if (rx_idx_ff == 4'h0 && rx_line) begin
               rx_act_ff <= 1'b0; // glitch, not a start bit
            end else if (rx_stop) begin
               rx_act_ff <= 1'b0;
               // low stop with nonzero data is a framing error: dropped
               rx_done_ff <= rx_line | rx_zero;
               rx_brk_ff <= ~rx_line;
            end else if (rx_idx_ff != 4'h0) begin
               rx_sh_ff <= {rx_line, rx_sh_ff[7:1]};
            end
         end else if (rx_act_ff) begin
            rx_cnt_ff <= rx_cnt_ff - CW'(1);
         end
      end
   end

   wire logic rx_byte_ev = rx_done_ff & ~rx_brk_ff;
   wire logic rx_brk_ev = rx_done_ff & rx_brk_ff;

   // ----------------------------------------------------------------
   // transmit selection
   // ----------------------------------------------------------------
   logic [1:0] left_ff;
   logic src_sp_ff;
   logic [15:0] addr_ff;

   wire logic boot_go = state_ff == mslk_pkg::ST_BOOT_BREAK
      && latched_ff && monitor_ff;
   wire logic sp_go = state_ff == mslk_pkg::ST_RESPOND
      && left_ff != 2'h0 && src_sp_ff && !tx_busy;
   wire logic ld_go = state_ff == mslk_pkg::ST_READ_LOAD;
   wire logic tx_start = boot_go | rx_done_ff | sp_go | ld_go;
   wire mslk_pkg::mslk_byte_t resp_byte = ld_go ? MEM_RDATA_I
      : (left_ff == 2'h2 ? STACK_POINTER_I[15:8] : STACK_POINTER_I[7:0]);
   wire mslk_pkg::mslk_byte_t tx_byte = rx_done_ff ? rx_sh_ff : resp_byte;
   wire logic [11:0] frame_pat = {3'b111, tx_byte, 1'b0};
   wire logic [11:0] tx_pat = boot_go ? `MSLK_BRK_PAT
      : rx_brk_ev ? `MSLK_BRK_ECHO_PAT : frame_pat;
   wire logic [3:0] tx_nbits = boot_go ? `MSLK_BRK_BITS
      : rx_brk_ev ? `MSLK_BRK_ECHO_BITS : `MSLK_FRAME_BITS;
   logic tx_line;

   mslk_tx #(
      .BIT_CYC(BIT_CYC),
      .PAT_W(12)
   ) u_tx (
      .clk_i(CLK_I),
      .nrst_i(NRST_I),
      .start_i(tx_start),
      .pat_i(tx_pat),
      .nbits_i(tx_nbits),
      .line_o(tx_line),
      .busy_o(tx_busy)
   );

   // only ever pulls low; high comes from the host pull-up
   assign MONITOR_SERIAL_PIN_O = 1'b0;
   assign MONITOR_SERIAL_PIN_OE_O = ~tx_line;

   // ----------------------------------------------------------------
   // command interpreter
   // ----------------------------------------------------------------
   mslk_pkg::mslk_byte_t cmd_ff;
   mslk_pkg::mslk_byte_t wdata_ff;
   logic we_ff;
   logic re_ff;
   logic rti_ff;

   wire mslk_pkg::mslk_byte_t rxb = rx_sh_ff;
   wire logic is_read = rxb == `MSLK_OP_READ;
   wire logic is_write = rxb == `MSLK_OP_WRITE;
   wire logic is_indexed_read_cmd = rxb == `MSLK_OP_INDEXED_READ_CMD;
   wire logic is_indexed_write_cmd = rxb == `MSLK_OP_INDEXED_WRITE_CMD;
   wire logic is_sp = rxb == `MSLK_OP_STACK_POINTER_READ_CMD;
   wire logic is_run = rxb == `MSLK_OP_RUN;
   wire logic op_ev = rx_byte_ev && state_ff == mslk_pkg::ST_OPCODE;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         mslk_pkg::ST_BOOT_BREAK: begin
            if (boot_go) nxt_state = mslk_pkg::ST_OPCODE;
         end
         mslk_pkg::ST_OPCODE: begin
            if (rx_byte_ev) begin
               if (is_read || is_write) begin
                  nxt_state = mslk_pkg::ST_ADDR_HI;
               end else if (is_indexed_read_cmd || is_sp) begin
                  nxt_state = mslk_pkg::ST_RESPOND;
               end else if (is_indexed_write_cmd) begin
                  nxt_state = mslk_pkg::ST_DATA;
               end
            end
         end
         mslk_pkg::ST_ADDR_HI: begin
            if (rx_byte_ev) nxt_state = mslk_pkg::ST_ADDR_LO;
         end
         mslk_pkg::ST_ADDR_LO: begin
            if (rx_byte_ev) begin
               nxt_state = cmd_ff == `MSLK_OP_READ
                  ? mslk_pkg::ST_RESPOND : mslk_pkg::ST_DATA;
            end
         end
         mslk_pkg::ST_DATA: begin
            if (rx_byte_ev) nxt_state = mslk_pkg::ST_OPCODE;
         end
         mslk_pkg::ST_RESPOND: begin
            if (left_ff == 2'h0) begin
               nxt_state = mslk_pkg::ST_OPCODE;
            end else if (!tx_busy && !src_sp_ff) begin
               nxt_state = mslk_pkg::ST_READ_ISSUE;
            end
         end
         mslk_pkg::ST_READ_ISSUE: nxt_state = mslk_pkg::ST_READ_LOAD;
         mslk_pkg::ST_READ_LOAD: nxt_state = mslk_pkg::ST_RESPOND;
         default: nxt_state = mslk_pkg::ST_OPCODE;
      endcase
      // a break restarts the command wherever it stood
      if (rx_brk_ev) nxt_state = mslk_pkg::ST_OPCODE;
   end

   wire logic resp_mem = op_ev && is_indexed_read_cmd
      || rx_byte_ev && state_ff == mslk_pkg::ST_ADDR_LO
         && cmd_ff == `MSLK_OP_READ;
   wire logic data_ev = rx_byte_ev && state_ff == mslk_pkg::ST_DATA;
   wire logic left_dec = sp_go || ld_go;

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         state_ff <= mslk_pkg::ST_BOOT_BREAK;
         cmd_ff <= 8'h00;
         addr_ff <= 16'h0000;
         wdata_ff <= 8'h00;
         left_ff <= 2'h0;
         src_sp_ff <= 1'b0;
         we_ff <= 1'b0;
         re_ff <= 1'b0;
         rti_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         we_ff <= data_ev;
         re_ff <= nxt_state == mslk_pkg::ST_READ_ISSUE;
         rti_ff <= op_ev && is_run;
         if (op_ev) cmd_ff <= rxb;
         if (rx_byte_ev && state_ff == mslk_pkg::ST_ADDR_HI) begin
            addr_ff[15:8] <= rxb;
         end else if (rx_byte_ev && state_ff == mslk_pkg::ST_ADDR_LO) begin
            addr_ff[7:0] <= rxb;
         end else if (we_ff || ld_go) begin
            addr_ff <= addr_ff + 16'h0001;
         end
         if (data_ev) wdata_ff <= rxb;
         if (resp_mem) begin
            left_ff <= cmd_ff == `MSLK_OP_READ && !op_ev ? 2'h1 : 2'h2;
            src_sp_ff <= 1'b0;
         end else if (op_ev && is_sp) begin
            left_ff <= 2'h2;
            src_sp_ff <= 1'b1;
         end else if (left_dec) begin
            left_ff <= left_ff - 2'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign MONITOR_MODE_O = monitor_ff;
   assign BUS_CLK_DIV4_O = div4_ff;
   assign WATCHDOG_ENABLE_O = wd_en_ff;
   assign RESET_VECTOR_O = rst_vec_ff;
   assign SWI_VECTOR_O = swi_vec_ff;
   assign RAM_JUMP_O = ram_jump_ff;
   assign RETURN_FROM_INTERRUPT_O = rti_ff;
   assign MEM_ADDR_O = addr_ff;
   assign MEM_WDATA_O = wdata_ff;
   assign MEM_WE_O = we_ff;
   assign MEM_RE_O = re_ff;

endmodule : mslk_link

// *** bench/mslk_link_asserts.sv ***
`timescale 1ns/1ns
module mslk_link_asserts #(
   parameter int unsigned BIT_CYC = 16
) (
   // clock and reset
   input wire logic CLK_I,
   input wire logic NRST_I,
   // watched pins
   input wire logic IRQ_TEST_HIGH_VOLTAGE_I,
   input wire logic WATCHDOG_DISABLE_BIT_I,
   input wire logic MONITOR_SERIAL_PIN_O,
   input wire logic MONITOR_SERIAL_PIN_OE_O,
   input wire logic MONITOR_MODE_O,
   input wire logic BUS_CLK_DIV4_O,
   input wire logic WATCHDOG_ENABLE_O,
   input wire logic WATCHDOG_RUN_O,
   input wire logic [15:0] RESET_VECTOR_O,
   input wire logic [15:0] SWI_VECTOR_O,
   input wire logic RAM_JUMP_O,
   input wire logic RETURN_FROM_INTERRUPT_O,
   input wire logic MEM_WE_O,
   input wire logic MEM_RE_O
);
   // -----------------
   // helper counters
   // -----------------
   // low_run_ff counts cycles of one unbroken device pull-down
   int unsigned low_run_ff;
   logic [3:0] up_ff;
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         low_run_ff <= 0;
         up_ff <= 4'h0;
      end else begin
         low_run_ff <= MONITOR_SERIAL_PIN_OE_O ? low_run_ff + 1 : 0;
         up_ff <= (up_ff == 4'hF) ? up_ff : up_ff + 4'h1;
      end
   end
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   a_low_run_max: assert property (low_run_ff <= 10 * BIT_CYC)
      else $error("pin pulled low longer than a break");
   a_bit_whole: assert property (
      (!MONITOR_SERIAL_PIN_OE_O && low_run_ff != 0)
      |-> (low_run_ff % BIT_CYC) == 0)
      else $error("low run is not a whole number of bits");
   a_pin_low_only: assert property (
      MONITOR_SERIAL_PIN_OE_O |-> !MONITOR_SERIAL_PIN_O)
      else $error("device drives the pin high");
   a_mode_held: assert property ((up_ff == 4'hF)
      |-> $stable(MONITOR_MODE_O) && $stable(BUS_CLK_DIV4_O))
      else $error("mode changed after capture");
   a_vec_pair: assert property ((RESET_VECTOR_O == 16'hFEFE)
      ? (SWI_VECTOR_O == 16'hFEFC)
      : (RESET_VECTOR_O == 16'hFFFE && SWI_VECTOR_O == 16'hFFFC))
      else $error("vector pair mixed");
   a_wd_gate: assert property (WATCHDOG_RUN_O ==
      (WATCHDOG_ENABLE_O && !WATCHDOG_DISABLE_BIT_I))
      else $error("watchdog run not gated by disable bit");
   a_wd_off: assert property ((IRQ_TEST_HIGH_VOLTAGE_I [*6])
      ##0 MONITOR_MODE_O |-> !WATCHDOG_ENABLE_O)
      else $error("watchdog enabled under test voltage");
   a_mem_pulse: assert property ((MEM_WE_O || MEM_RE_O)
      |=> !(MEM_WE_O || MEM_RE_O))
      else $error("memory strobe longer than one cycle");
   a_rti_pulse: assert property (RETURN_FROM_INTERRUPT_O
      |=> !RETURN_FROM_INTERRUPT_O)
      else $error("return pulse longer than one cycle");
   a_jump_user: assert property (RAM_JUMP_O
      |-> !MONITOR_MODE_O ##1 !RAM_JUMP_O)
      else $error("ram jump pulse wrong");
endmodule : mslk_link_asserts

bind mslk_link mslk_link_asserts #(.BIT_CYC(BIT_CYC)) mslk_link_asserts_inst (
   .CLK_I(CLK_I),
   .NRST_I(NRST_I),
   .IRQ_TEST_HIGH_VOLTAGE_I(IRQ_TEST_HIGH_VOLTAGE_I),
   .WATCHDOG_DISABLE_BIT_I(WATCHDOG_DISABLE_BIT_I),
   .MONITOR_SERIAL_PIN_O(MONITOR_SERIAL_PIN_O),
   .MONITOR_SERIAL_PIN_OE_O(MONITOR_SERIAL_PIN_OE_O),
   .MONITOR_MODE_O(MONITOR_MODE_O),
   .BUS_CLK_DIV4_O(BUS_CLK_DIV4_O),
   .WATCHDOG_ENABLE_O(WATCHDOG_ENABLE_O),
   .WATCHDOG_RUN_O(WATCHDOG_RUN_O),
   .RESET_VECTOR_O(RESET_VECTOR_O),
   .SWI_VECTOR_O(SWI_VECTOR_O),
   .RAM_JUMP_O(RAM_JUMP_O),
   .RETURN_FROM_INTERRUPT_O(RETURN_FROM_INTERRUPT_O),
   .MEM_WE_O(MEM_WE_O),
   .MEM_RE_O(MEM_RE_O)
);

// *** bench/mslk_host.sv ***
`timescale 1ns/1ns
module mslk_host #(
   parameter int unsigned BIT_CYC = 16
) (
   // clock
   input wire logic clk_i,
   // monitor pin
   input wire logic line_i,
   output logic drive_o
);
   // ---------------
   // serial host
   // ---------------
   int unsigned bit_len = BIT_CYC;
   initial drive_o = 1'b0;
   // only pulls low; the pull-up makes every high level
   task automatic put_bit(input logic v);
      drive_o <= ~v;
      repeat (bit_len) @(posedge clk_i);
   endtask : put_bit
   // start low, lsb first, stop high, one rate both ways
   task automatic send_byte(input logic [7:0] b);
      @(posedge clk_i);
      put_bit(1'b0);
      for (int i = 0; i < 8; i++) begin
         put_bit(b[i]);
      end
      drive_o <= 1'b0;
      repeat (bit_len / 2) @(posedge clk_i);
   endtask : send_byte
   // start plus nine low bits
   task automatic send_break();
      @(posedge clk_i);
      repeat (10) put_bit(1'b0);
      drive_o <= 1'b0;
   endtask : send_break
   task automatic recv_byte(output logic [7:0] b, output logic ok);
      int unsigned w;
      w = 0;
      ok = 1'b0;
      b = 8'h00;
      do begin
         @(posedge clk_i);
         w++;
      end while (line_i !== 1'b0 && w < 40 * bit_len);
      repeat (bit_len / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_len) @(posedge clk_i);
         b[i] = line_i;
      end
      repeat (bit_len) @(posedge clk_i);
      ok = (line_i === 1'b1) && (w < 40 * bit_len);
   endtask : recv_byte
   // times a break and adopts its bit length as the rate
   task automatic low_run(output int unsigned n);
      int unsigned w;
      n = 0;
      w = 0;
      do begin
         @(posedge clk_i);
         w++;
      end while (line_i !== 1'b0 && w < 400);
      while (line_i === 1'b0 && n < 2000) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 10) bit_len = n / 10;
   endtask : low_run
endmodule : mslk_host

// *** bench/mslk_link_test.sv ***
`timescale 1ns/1ns
module mslk_link_test;
   localparam int unsigned BIT = 16;
   // ---------------------
   // stimulus and models
   // ---------------------
   logic clk, nrst, irq_v, rst_v, st_a, st_b, byp, wd_dis, host_low, pin_w;
   logic oe, pin_o, mode, div4, wd_en, wd_run, jump, return_from_interrupt, we, re;
   logic jump_seen, rti_seen, ok;
   logic [15:0] rst_vec, swi_vec, addr, sp, we_addr;
   logic [7:0] wdata, rdata, we_data, rb;
   logic [7:0] mem [0:255];
   int unsigned error_cnt, checked, n;
   // a released pin floats high through the pull-up
   assign pin_w = (oe ? pin_o : 1'b1) & ~host_low;
   mslk_link #(.BIT_CYC(BIT)) mslk_link_inst (
      .CLK_I(clk),
      .NRST_I(nrst),
      .IRQ_TEST_HIGH_VOLTAGE_I(irq_v),
      .RST_TEST_HIGH_VOLTAGE_I(rst_v),
      .MODE_STRAP_A_I(st_a),
      .MODE_STRAP_B_I(st_b),
      .DIVIDER_BYPASS_STRAP_I(byp),
      .WATCHDOG_DISABLE_BIT_I(wd_dis),
      .MONITOR_SERIAL_PIN_I(pin_w),
      .MONITOR_SERIAL_PIN_O(pin_o),
      .MONITOR_SERIAL_PIN_OE_O(oe),
      .MONITOR_MODE_O(mode),
      .BUS_CLK_DIV4_O(div4),
      .WATCHDOG_ENABLE_O(wd_en),
      .WATCHDOG_RUN_O(wd_run),
      .RESET_VECTOR_O(rst_vec),
      .SWI_VECTOR_O(swi_vec),
      .RAM_JUMP_O(jump),
      .RETURN_FROM_INTERRUPT_O(return_from_interrupt),
      .MEM_ADDR_O(addr),
      .MEM_WDATA_O(wdata),
      .MEM_WE_O(we),
      .MEM_RE_O(re),
      .MEM_RDATA_I(rdata),
      .STACK_POINTER_I(sp)
   );
   mslk_host #(.BIT_CYC(BIT)) mslk_host_inst (
      .clk_i(clk),
      .line_i(pin_w),
      .drive_o(host_low)
   );
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // read data lands one cycle after the strobe
   always @(posedge clk) begin
      if (re) rdata <= mem[addr[7:0]];
      if (we) mem[addr[7:0]] <= wdata;
      if (we) we_addr <= addr;
      if (we) we_data <= wdata;
      if (jump) jump_seen <= 1'b1;
      if (return_from_interrupt) rti_seen <= 1'b1;
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done
   // s = {irq voltage, strap a, strap b, pin held low, bypass}
   task automatic do_reset(input logic [4:0] s);
      @(posedge clk);
      nrst <= 1'b0;
      {irq_v, st_a, st_b, byp} <= {s[4:2], s[0]};
      mslk_host_inst.drive_o <= s[1];
      jump_seen <= 1'b0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : do_reset
   // the guard bit lets the device finish its own stop bit first
   task automatic xfer(input logic [7:0] b);
      repeat (BIT) @(posedge clk);
      mslk_host_inst.send_byte(b);
      mslk_host_inst.recv_byte(rb, ok);
      check({7'h00, ok, rb}, {8'h01, b});
   endtask : xfer
   task automatic rx(input logic [7:0] e);
      mslk_host_inst.recv_byte(rb, ok);
      check({7'h00, ok, rb}, {8'h01, e});
   endtask : rx
   initial begin
      nrst = 1'b0;
      {irq_v, rst_v, st_a, st_b, byp, wd_dis} = 6'h00;
      sp = 16'h2468;
      rdata = 8'h00;
      {jump_seen, rti_seen} = 2'h0;
      error_cnt = 0;
      checked = 0;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'(i) ^ 8'h3C;
      end
      do_reset(5'h18);
      mslk_host_inst.low_run(n);
      check(n[15:0], 16'h00A0);
      check(16'({mode, div4, wd_en}), 16'h0004);
      check(rst_vec, 16'hFEFE);
      check(swi_vec, 16'hFEFC);
      st_a <= 1'b0;
      byp <= 1'b1;
      repeat (8) @(posedge clk);
      check(16'({mode, div4}), 16'h0002);
      done("entry");
      xfer(8'h49);
      xfer(8'h12);
      xfer(8'h34);
      xfer(8'hA5);
      check(we_addr, 16'h1234);
      check(16'(we_data), 16'h00A5);
      xfer(8'h4A);
      xfer(8'h12);
      xfer(8'h34);
      rx(8'hA5);
      xfer(8'h1A);
      rx(8'h09);
      rx(8'h0A);
      xfer(8'h19);
      xfer(8'h77);
      check(we_addr, 16'h1237);
      xfer(8'h0C);
      rx(8'h24);
      rx(8'h68);
      rti_seen <= 1'b0;
      xfer(8'h28);
      check(16'(rti_seen), 16'h0001);
      done("commands");
      xfer(8'h55);
      repeat (BIT) @(posedge clk);
      mslk_host_inst.send_break();
      mslk_host_inst.low_run(n);
      check(n[15:0], 16'h00A0);
      xfer(8'h0C);
      rx(8'h24);
      rx(8'h68);
      done("break");
      {irq_v, rst_v} <= 2'h1;
      repeat (8) @(posedge clk);
      check(16'(wd_en), 16'h0000);
      rst_v <= 1'b0;
      repeat (8) @(posedge clk);
      check(16'({wd_en, wd_run}), 16'h0003);
      wd_dis <= 1'b1;
      repeat (2) @(posedge clk);
      check(16'({wd_en, wd_run}), 16'h0002);
      done("watchdog");
      do_reset(5'h1A);
      repeat (4) @(posedge clk);
      check(16'({jump_seen, mode}), 16'h0002);
      check(swi_vec, 16'hFEFC);
      check(16'(wd_en), 16'h0000);
      do_reset(5'h19);
      mslk_host_inst.low_run(n);
      check(16'({mode, div4}), 16'h0003);
      do_reset(5'h01);
      repeat (6) @(posedge clk);
      check(16'({mode, div4, wd_en}), 16'h0003);
      check(rst_vec, 16'hFFFE);
      check(swi_vec, 16'hFFFC);
      done("modes");
      end_sim();
   end
   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      $display("Error at %0t: time limit, checks %h", $time, checked);
      end_sim();
   end
endmodule : mslk_link_test
